/* design/core_clk_pkg.sv */
// Package with register map, field layout and rate constants for the core clock control block.
package core_clk_pkg;

	localparam logic [15:0] CORE_RATE_SELECT_ADDR     = 16'hE220;
	localparam logic [15:0] SUBSYSTEM_CLOCK_GATE_ADDR = 16'hE280;

	localparam int          SEL_W          = 5;
	localparam logic [4:0]  SEL_RESET      = 5'h00;
	localparam logic [4:0]  SEL_BASE       = 5'h00;
	localparam logic [4:0]  SEL_DOUBLE     = 5'h01;
	localparam logic [4:0]  SEL_FOURFOLD   = 5'h02;
	localparam logic [4:0]  SEL_IN_FIRST   = 5'h03;
	localparam logic [4:0]  SEL_IN_LAST    = 5'h0E;
	localparam logic [4:0]  SEL_OUT_FIRST  = 5'h0F;
	localparam logic [4:0]  SEL_OUT_LAST   = 5'h1A;
	localparam logic [4:0]  SEL_SPDIF      = 5'h1B;
	localparam int          PAIRS          = 12;

	localparam int          GATE_W         = 9;
	localparam logic [8:0]  GATE_RESET     = 9'h000;
	localparam int          GATE_ROUTING   = 0;
	localparam int          GATE_SER_IN    = 1;
	localparam int          GATE_SER_OUT   = 2;
	localparam int          GATE_SRC_LO    = 3;
	localparam int          GATE_SRC_HI    = 4;
	localparam int          GATE_CORE      = 5;
	localparam int          GATE_SPDIF_RX  = 6;
	localparam int          GATE_SPDIF_TX  = 7;
	localparam int          GATE_AUX_ADC   = 8;

	localparam int          CORE_PER_BASE     = 3584;
	localparam int          CORE_PER_DOUBLE   = 1792;
	localparam int          CORE_PER_FOURFOLD = 896;
	localparam int          PLL_MULT          = 56;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [PAIRS-1:0] ser_in;
		logic [PAIRS-1:0] ser_out;
		logic             spdif;
	} frame_sync_t;

endpackage : core_clk_pkg

/* design/pulse_select.sv */
// Start pulse multiplexer: internal rate ticks and synchronised frame-sync edges.
module pulse_select
(
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic [4:0]                 sel,
	input  wire logic [2:0]                 rate_tick,
	input  wire core_clk_pkg::frame_sync_t  sync_in,
	output logic                            start_pulse,
	output logic                            core_disabled
);

	localparam int N = 2 * core_clk_pkg::PAIRS + 1;

	logic [N-1:0] s1_q;
	logic [N-1:0] s2_q;
	logic [N-1:0] s3_q;
	logic [N-1:0] lvl_q;
	logic [N-1:0] rise;

	// Three-stage sync; a level counts once stages two and three agree.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			lvl_q <= '0;
		end
		else
		begin
			s1_q <= sync_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < N; i++)
				if (s2_q[i] == s3_q[i])
					lvl_q[i] <= s3_q[i];
		end
	end

	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_edge
			assign rise[g] = (s2_q[g] == s3_q[g]) && s3_q[g] && !lvl_q[g];
		end
	endgenerate

	// Sync vector order: spdif at bit 0, outputs at 1..12, inputs at 13..24.
	always_comb
	begin
		start_pulse   = 1'b0;
		core_disabled = 1'b0;
		if (sel <= core_clk_pkg::SEL_FOURFOLD)
			start_pulse = rate_tick[sel[1:0]];
		else if (sel <= core_clk_pkg::SEL_IN_LAST)
			start_pulse = rise[5'(sel - core_clk_pkg::SEL_IN_FIRST) + 5'd13];
		else if (sel <= core_clk_pkg::SEL_OUT_LAST)
			start_pulse = rise[5'(sel - core_clk_pkg::SEL_OUT_FIRST) + 5'd1];
		else if (sel == core_clk_pkg::SEL_SPDIF)
			start_pulse = rise[0];
		else
			core_disabled = 1'b1;
	end

endmodule : pulse_select

/* design/core_rate_and_clock_gating.sv */
// Top of the core start pulse selection and subsystem clock gating block.

// How it works
// - Core start pulse comes from exactly one selected source.
// - Reset selects the base rate; a base period is 3584 core clock cycles.
// - Gate bit 0 stops the master clock to its subsystem; 1 passes it.
// - Bits 8..5: aux converters, transmitter, receiver, core.
// - Bits 4..0: converters 7-4, 3-0, serial out, serial in, routing.
// - All gate bits reset to zero.
// - Select field is bits 4..0, resets zero; codes 0..2 internal rates.
// - Codes 3..14 pick serial input pairs 0..11.
// - Codes 15..26 pick serial output pairs 0..11.
// - Code 27 picks the receiver's recovered frame sync.
// - Codes 28..31 give no start pulse; core disabled.
// - A selected pair's pulse follows its frame-sync clock.
// - Core clock is the 64x base clock multiplied by 56.
module core_rate_and_clock_gating
#(
	parameter int BASE_DIV = core_clk_pkg::CORE_PER_BASE
)
(
	input  wire logic                       clk,
	input  wire logic                       rst_b,
	input  wire core_clk_pkg::reg_req_t     req,
	output logic [15:0]                     rdata,
	input  wire core_clk_pkg::frame_sync_t  frame_sync,
	output logic                            start_pulse,
	output logic                            core_disabled,
	output logic [8:0]                      clk_enable,
	output logic                            core_clk_en
);

	localparam int RATE_DIV_W = $clog2(BASE_DIV);

	logic                 rst_m_q;
	logic                 rst_n;
	logic [4:0]           sel_q;
	logic [8:0]           gate_q;
	logic [RATE_DIV_W-1:0] div_q;
	logic [2:0]           rate_tick;
	logic [15:0]          rdata_q;

	//////////////////////////////////////////////////////////////////////////
	// Register decode shared by the write logic and the checks.
	function automatic logic reg_hit
	(
		input logic        strobe,
		input logic [15:0] addr,
		input logic [15:0] reg_addr
	);
		return strobe && addr == reg_addr;
	endfunction : reg_hit

	//////////////////////////////////////////////////////////////////////////
	// Reset release through two flip-flops.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_m_q <= 1'b0;
			rst_n   <= 1'b0;
		end
		else
		begin
			rst_m_q <= 1'b1;
			rst_n   <= rst_m_q;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Registers.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sel_q <= core_clk_pkg::SEL_RESET;
		else if (reg_hit(req.wr, req.addr, core_clk_pkg::CORE_RATE_SELECT_ADDR))
			sel_q <= req.wdata[4:0];
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			gate_q <= core_clk_pkg::GATE_RESET;
		else if (reg_hit(req.wr, req.addr, core_clk_pkg::SUBSYSTEM_CLOCK_GATE_ADDR))
			gate_q <= req.wdata[8:0];
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_q <= 16'h0000;
		else if (req.rd)
		begin
			case (req.addr)
				core_clk_pkg::CORE_RATE_SELECT_ADDR:     rdata_q <= {11'h000, sel_q};
				core_clk_pkg::SUBSYSTEM_CLOCK_GATE_ADDR: rdata_q <= {7'h00, gate_q};
				default:                                 rdata_q <= 16'h0000;
			endcase
		end
	end

	assign rdata = rdata_q;

	//////////////////////////////////////////////////////////////////////////
	// Internal rate ticks: one core-clock cycle stands for one core instruction,
	// so a frame spans 3584, 1792 or 896 cycles of clk.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			div_q <= '0;
		else if (!gate_q[core_clk_pkg::GATE_CORE])
			div_q <= '0;
		else if (div_q == RATE_DIV_W'(BASE_DIV - 1))
			div_q <= '0;
		else
			div_q <= div_q + 1'b1;
	end

	assign rate_tick[0] = gate_q[core_clk_pkg::GATE_CORE] && div_q == '0;
	assign rate_tick[1] = gate_q[core_clk_pkg::GATE_CORE]
		&& (div_q == '0 || div_q == RATE_DIV_W'(BASE_DIV / 2));
	assign rate_tick[2] = gate_q[core_clk_pkg::GATE_CORE] && (div_q == '0
		|| div_q == RATE_DIV_W'(BASE_DIV / 4) || div_q == RATE_DIV_W'(BASE_DIV / 2)
		|| div_q == RATE_DIV_W'(3 * BASE_DIV / 4));

	//////////////////////////////////////////////////////////////////////////
	// Start pulse selection.
	pulse_select u_sel
	(
		.clk           (clk),
		.rst_n         (rst_n),
		.sel           (sel_q),
		.rate_tick     (rate_tick),
		.sync_in       (frame_sync),
		.start_pulse   (start_pulse),
		.core_disabled (core_disabled)
	);

	// Gate enables map one to one onto the subsystems.
	assign clk_enable  = gate_q;
	assign core_clk_en = gate_q[core_clk_pkg::GATE_CORE];

	//////////////////////////////////////////////////////////////////////////
	// Checks.
	a_gate_reset: assert property (@(posedge clk) $rose(rst_n) |-> clk_enable == 9'h000)
		else $error("gates not cleared at reset");
	a_sel_write: assert property (@(posedge clk) disable iff (!rst_n)
		req.wr && req.addr == core_clk_pkg::CORE_RATE_SELECT_ADDR
		|=> sel_q == $past(req.wdata[4:0]))
		else $error("select write lost");
	a_gate_write: assert property (@(posedge clk) disable iff (!rst_n)
		req.wr && req.addr == core_clk_pkg::SUBSYSTEM_CLOCK_GATE_ADDR
		|=> clk_enable == $past(req.wdata[8:0]))
		else $error("gate write lost");
	a_no_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		sel_q >= 5'h1C |-> !start_pulse && core_disabled)
		else $error("pulse while disabled");
	a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
		$past(req.rd) |-> rdata[15:9] == 7'h00)
		else $error("reserved bits not zero");
	a_core_gate: assert property (@(posedge clk) disable iff (!rst_n)
		reg_hit(req.wr, req.addr, core_clk_pkg::SUBSYSTEM_CLOCK_GATE_ADDR)
		|=> core_clk_en == $past(req.wdata[5]))
		else $error("core gate bit wrong");
	a_base_period: assert property (@(posedge clk) disable iff (!rst_n)
		rate_tick[0] && gate_q[5] ##1 gate_q[5] [*8] |-> !rate_tick[0])
		else $error("base tick too early");
	a_tick_gated: assert property (@(posedge clk) disable iff (!rst_n)
		!gate_q[5] |-> rate_tick == 3'b000)
		else $error("tick without core clock");
	a_sel_reset: assert property (@(posedge clk)
		$rose(rst_n) |-> sel_q == core_clk_pkg::SEL_RESET)
		else $error("select not cleared at reset");
	a_read_select: assert property (@(posedge clk) disable iff (!rst_n)
		$past(req.rd) && $past(req.addr) == core_clk_pkg::CORE_RATE_SELECT_ADDR
		|-> rdata == {11'h000, $past(sel_q)})
		else $error("select read wrong");
	a_read_gate: assert property (@(posedge clk) disable iff (!rst_n)
		$past(req.rd) && $past(req.addr) == core_clk_pkg::SUBSYSTEM_CLOCK_GATE_ADDR
		|-> rdata == {7'h00, $past(clk_enable)})
		else $error("gate read wrong");
	a_unmapped_read: assert property (@(posedge clk) disable iff (!rst_n)
		$past(req.rd) && $past(req.addr) != core_clk_pkg::CORE_RATE_SELECT_ADDR
		&& $past(req.addr) != core_clk_pkg::SUBSYSTEM_CLOCK_GATE_ADDR |-> rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_gate_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!reg_hit(req.wr, req.addr, core_clk_pkg::SUBSYSTEM_CLOCK_GATE_ADDR)
		|=> $stable(clk_enable))
		else $error("gate changed without write");
	a_enabled_level: assert property (@(posedge clk) disable iff (!rst_n)
		sel_q <= core_clk_pkg::SEL_SPDIF |-> !core_disabled)
		else $error("core disabled on a live code");
	a_base_source: assert property (@(posedge clk) disable iff (!rst_n)
		sel_q == core_clk_pkg::SEL_BASE |-> start_pulse == rate_tick[0])
		else $error("base rate not routed");

	//////////////////////////////////////////////////////////////////////////
	// Tick spacing watch: while the core clock runs each internal rate ticks
	// once per full, half or quarter frame; a gate-off restarts the count.
	genvar t;
	generate
		for (t = 0; t < 3; t++)
		begin : g_tick_watch
			localparam int PERIOD = BASE_DIV >> t;

			logic [RATE_DIV_W-1:0] gap_q;
			logic                  seen_q;

			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					gap_q  <= '0;
					seen_q <= 1'b0;
				end
				else if (!gate_q[core_clk_pkg::GATE_CORE])
				begin
					gap_q  <= '0;
					seen_q <= 1'b0;
				end
				else if (rate_tick[t])
				begin
					gap_q  <= '0;
					seen_q <= 1'b1;
				end
				else
					gap_q <= gap_q + 1'b1;
			end

			a_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n)
				rate_tick[t] && seen_q |-> gap_q == RATE_DIV_W'(PERIOD - 1))
				else $error("rate tick spacing wrong");
		end
	endgenerate

endmodule : core_rate_and_clock_gating

/* testbench/core_rate_and_clock_gating_test.sv */
// Self-checking bench for the core start pulse selection and clock gating block.
module core_rate_and_clock_gating_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] gate_addr = core_clk_pkg::SUBSYSTEM_CLOCK_GATE_ADDR;
	localparam logic [15:0] sel_addr = core_clk_pkg::CORE_RATE_SELECT_ADDR;
	logic                      clk = 1'b0;
	logic                      rst_b = 1'b0;
	core_clk_pkg::reg_req_t    req = '0;
	core_clk_pkg::frame_sync_t fs = '0;
	logic [15:0]               rdata;
	logic                      start_pulse;
	logic                      core_disabled;
	logic [8:0]                clk_enable;
	logic                      core_clk_en;
	logic                      rd_q = 1'b0;
	logic [15:0]               exp_q[$];
	logic [15:0]               d;
	int                        errors = 0;
	int                        checks = 0;
	int                        cyc = 0;
	int                        k;
	int                        seed = 32'hab9c;

	core_rate_and_clock_gating #(.BASE_DIV(16)) i_core_rate_and_clock_gating
	(
		.clk(clk), .rst_b(rst_b), .req(req), .rdata(rdata), .frame_sync(fs),
		.start_pulse(start_pulse), .core_disabled(core_disabled),
		.clk_enable(clk_enable), .core_clk_en(core_clk_en)
	);

	always #50 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	task cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : cmp

	task wr(input logic [15:0] a, input logic [15:0] v);
		@(posedge clk);
		#10 req.wr = 1'b1;
		req.addr = a;
		req.wdata = v;
		@(posedge clk);
		#10 req.wr = 1'b0;
	endtask : wr

	// The expected word is queued before the strobe so the monitor finds it in order.
	task rd(input logic [15:0] a, input logic [15:0] v);
		exp_q.push_back(v);
		@(posedge clk);
		#10 req.rd = 1'b1;
		req.addr = a;
		@(posedge clk);
		#10 req.rd = 1'b0;
		@(posedge clk);
	endtask : rd

	// Waits up to lim cycles for a start pulse and leaves the cycle count in k.
	task wait_p(input int lim);
		k = 0;
		do
		begin
			@(posedge clk);
			#5 k++;
		end
		while (start_pulse !== 1'b1 && k < lim);
	endtask : wait_p

	task give_verdict;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		rd_q <= req.rd;
		if (rd_q)
			cmp(rdata, exp_q.pop_front(), "read data");
		if (cyc == 20000)
		begin
			errors++;
			give_verdict();
		end
	end

	initial
	begin
		repeat (12) @(posedge clk);
		#10 rst_b = 1'b1;
		repeat (3) @(posedge clk);
		cmp({7'h00, clk_enable}, 16'h0000, "gate reset");
		rd(gate_addr, 16'h0000);
		rd(sel_addr, 16'h0000);
		wait_p(40);
		cmp({15'h0, start_pulse}, 16'h0000, "gated core pulse");
		$display("test reset done");
		repeat (4)
		begin
			d = 16'($random(seed));
			wr(gate_addr, d);
			cmp({7'h00, clk_enable}, d & 16'h01FF, "enables");
			cmp({15'h0, core_clk_en}, {15'h0, d[5]}, "core gate");
			rd(gate_addr, d & 16'h01FF);
		end
		wr(16'hE240, 16'($random(seed)));
		rd(16'hE240, 16'h0000);
		rd(gate_addr, d & 16'h01FF);
		wr(gate_addr, 16'h01FF);
		$display("test gate done");
		for (int c = 0; c < 32; c++)
		begin
			wr(sel_addr, 16'hFFE0 | 16'(c));
			rd(sel_addr, 16'(c));
			cmp({15'h0, core_disabled}, {15'h0, c >= 28}, "disable");
		end
		wait_p(40);
		cmp({15'h0, start_pulse}, 16'h0000, "no pulse");
		for (int r = 0; r < 3; r++)
		begin
			wr(sel_addr, 16'(r));
			wait_p(100);
			wait_p(100);
			cmp(16'(k), 16'(16 >> r), "tick period");
		end
		wr(gate_addr, 16'h01DF);
		wait_p(40);
		cmp({15'h0, start_pulse}, 16'h0000, "core gated");
		wr(gate_addr, 16'h01FF);
		$display("test rates done");
		for (int c = 3; c < 28; c++)
		begin
			wr(sel_addr, 16'(c));
			fs = '1;
			if (c < 15)
				fs.ser_in[c-3] = 1'b0;
			else if (c < 27)
				fs.ser_out[c-15] = 1'b0;
			else
				fs.spdif = 1'b0;
			wait_p(8);
			cmp({15'h0, start_pulse}, 16'h0000, "other source");
			#5 fs = '1;
			wait_p(6);
			cmp({15'h0, start_pulse}, 16'h0001, "frame sync");
			#5 fs = '0;
			repeat (6) @(posedge clk);
		end
		$display("test frame sync done");
		#10 rst_b = 1'b0;
		repeat (2) @(posedge clk);
		#10 rst_b = 1'b1;
		repeat (3) @(posedge clk);
		cmp({7'h00, clk_enable}, 16'h0000, "gate after reset");
		rd(sel_addr, 16'h0000);
		$display("test second reset done");
		give_verdict();
	end
endmodule : core_rate_and_clock_gating_test
